// >>> hw/odc_pkg.sv
// odc_pkg: constants, types and states shared by the debug command unit.
// assumes one 100 MHz system clock and a byte-wide command stream.
package odc_pkg;

  // command bytes
  localparam logic [7:0] CMD_RD_STATUS = 8'h02;
  localparam logic [7:0] CMD_WR_CTL    = 8'h04;
  localparam logic [7:0] CMD_RD_CTL    = 8'h05;
  localparam logic [7:0] CMD_WR_PM     = 8'h0a;
  localparam logic [7:0] CMD_RD_PM     = 8'h0b;
  localparam logic [7:0] CMD_WR_DM     = 8'h0c;
  localparam logic [7:0] CMD_RD_DM     = 8'h0d;
  localparam logic [7:0] CMD_PM_CRC    = 8'h0e;
  localparam logic [7:0] CMD_STEP      = 8'h10;
  localparam logic [7:0] CMD_STUFF     = 8'h11;
  localparam logic [7:0] CMD_EXEC      = 8'h12;
  localparam logic [7:0] CMD_RD_BAUD   = 8'h1b;

  // debugger_control field positions
  localparam int CTL_HALT_FOR_DEBUG = 7;
  localparam int CTL_BRK_ALLOW      = 6;
  localparam int CTL_ACK_SEND       = 5;
  localparam int CTL_SPIN           = 4;
  localparam int CTL_PC_MATCH       = 3;
  localparam int CTL_CNT_ZERO       = 2;
  localparam int CTL_SYS_RESET      = 0;
  localparam logic [7:0] CTL_RESET  = 8'h00;

  // debugger_status field positions
  localparam int STAT_IDLE = 7;
  localparam int STAT_HALT = 6;
  localparam int STAT_RP   = 5;

  // reply values
  localparam logic [7:0]  BLOCKED_BYTE = 8'hff;
  localparam logic [7:0]  ACK_CHAR     = 8'hff;
  localparam logic [15:0] BLOCKED_CRC  = 16'hffff;
  localparam logic [15:0] CRC_PRESET   = 16'hffff;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408; // x16+x12+x5+1, lsb first
  localparam logic [15:0] CNT_RESET    = 16'hffff;
  localparam int          HDR_BYTES    = 4;

  // memory request bundle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } odc_mem_req_s;

  typedef enum {
    S_IDLE, S_HDR, S_WDATA, S_RD_ISSUE, S_RD_WAIT, S_RD_PUSH,
    S_CRC_RD, S_CRC_ACC, S_SEND, S_CTL, S_STUFF, S_EXEC
  } odc_state_e;

endpackage

// >>> hw/odc_unit.sv
// odc_unit: debug command unit (memory access, crc, stepping, control and
// status) plus its reply fifo. assumes a serial layer on the same clock that
// delivers host bytes as one-cycle strobes and drains reply bytes.
`timescale 1ns/1ps

// reply fifo with valid/ready on both sides
module odc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,       // system clock
  input  wire logic             resetn,    // sync reset, low
  input  wire logic             in_valid,  // write strobe
  output logic                  in_ready,  // space left
  input  wire logic [WIDTH-1:0] in_data,   // write data
  output logic                  out_valid, // data present
  input  wire logic             out_ready, // drain strobe
  output logic      [WIDTH-1:0] out_data   // head of queue
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module odc_unit
  import odc_pkg::*;
#(
  parameter int PM_BYTES   = 65536, // program memory size covered by the crc
  parameter int FIFO_DEPTH = 8      // reply fifo depth
) (
  input  wire logic         clk,             // system clock
  input  wire logic         resetn,          // sync reset, low
  input  wire logic         rx_valid,        // host byte strobe
  input  wire logic [7:0]   rx_data,         // host byte
  output logic              tx_valid,        // reply byte present
  input  wire logic         tx_ready,        // serial layer takes byte
  output logic      [7:0]   tx_data,         // reply byte
  output odc_mem_req_s      pm_req,          // program memory request
  input  wire logic [7:0]   pm_rdata,        // read data, in the cycle of the request
  output odc_mem_req_s      dm_req,          // data memory request
  input  wire logic [7:0]   dm_rdata,        // read data, in the cycle of the request
  input  wire logic         flash_unlocked,  // flash controller unlocked
  input  wire logic         rp_option_n,     // read-protect option, 0 = on
  input  wire logic         halt_mode,       // cpu in halt mode
  input  wire logic         spin_cfg,        // loop-on-break setting
  input  wire logic         brk_decoded,     // cpu decoded break opcode
  input  wire logic [15:0]  pc,              // program counter
  input  wire logic [15:0]  baud_reload,     // measured baud reload
  input  wire logic [2:0]   instr_len,       // length of opcode on rx_data
  input  wire logic         sys_reset_done,  // device reset finished
  output logic              step_ff,         // step one instruction
  output logic              stuff_ff,        // stuff opcode strobe
  output logic              exec_valid_ff,   // executed byte strobe
  output logic      [7:0]   exec_byte_ff,    // opcode or instruction byte
  output logic              exec_last_ff,    // last byte of instruction
  output logic      [7:0]   ctl_ff,          // debugger_control
  output logic      [7:0]   stat_ff,         // debugger_status
  output logic      [15:0]  cnt_ff           // debug_down_counter
);

  // lsb-first crc over one byte
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
    end
    return r;
  endfunction

  odc_state_e   state_ff;
  logic [7:0]   cmd_ff;
  logic [31:0]  hdr_ff;
  logic [2:0]   hdr_cnt_ff;
  logic [16:0]  left_ff;
  logic [16:0]  crc_addr_ff;
  logic [15:0]  crc_ff;
  logic [15:0]  reply_ff;
  logic [1:0]   reply_cnt_ff;
  logic [7:0]   byte_ff;
  logic [2:0]   exec_left_ff;
  logic         idle_seen_ff;
  logic         ack_pend_ff;
  logic         in_dbg;
  logic         rp_on;
  logic         running;
  logic         pc_hit;
  logic         zero_hit;
  logic         brk_take;
  logic         brk_event;
  logic         ctl_write;
  logic         fifo_ready;
  logic         push_valid;
  logic [7:0]   push_data;
  logic         fsm_push;
  logic         ack_push;

  assign in_dbg   = ctl_ff[CTL_HALT_FOR_DEBUG];
  assign rp_on    = ~rp_option_n;
  assign running  = ~in_dbg;

  // break sources while the cpu runs
  assign brk_take = running & brk_decoded & ctl_ff[CTL_BRK_ALLOW];
  assign pc_hit   = running & ctl_ff[CTL_PC_MATCH] & (pc == cnt_ff);
  assign zero_hit = running & ctl_ff[CTL_CNT_ZERO] & (cnt_ff == '0);
  assign brk_event = brk_take | pc_hit | zero_hit;
  assign ctl_write = (state_ff == S_CTL) & rx_valid;

  // reply push: command replies first, the ack byte waits for a gap
  always_comb begin
    fsm_push  = 1'b0;
    push_data = reply_ff[15:8];
    case (state_ff)
      S_SEND:    fsm_push = 1'b1;
      S_RD_PUSH: begin
        fsm_push  = 1'b1;
        push_data = byte_ff;
      end
      default:   fsm_push = 1'b0;
    endcase
    ack_push = ack_pend_ff & ~fsm_push;
    if (ack_push) begin
      push_data = ACK_CHAR;
    end
    push_valid = fsm_push | ack_push;
  end

  odc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (push_valid),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // command sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff     <= S_IDLE;
      cmd_ff       <= '0;
      hdr_ff       <= '0;
      hdr_cnt_ff   <= '0;
      left_ff      <= '0;
      crc_addr_ff  <= '0;
      crc_ff       <= CRC_PRESET;
      reply_ff     <= '0;
      reply_cnt_ff <= '0;
      byte_ff      <= '0;
      exec_left_ff <= '0;
    end else begin
      case (state_ff)
        S_IDLE: if (rx_valid) begin
          cmd_ff     <= rx_data;
          hdr_cnt_ff <= '0;
          case (rx_data)
            CMD_WR_PM, CMD_RD_PM, CMD_WR_DM, CMD_RD_DM: state_ff <= S_HDR;
            CMD_WR_CTL: state_ff <= S_CTL;
            CMD_STUFF:  state_ff <= S_STUFF;
            CMD_EXEC:   state_ff <= S_EXEC;
            CMD_RD_STATUS: begin
              reply_ff     <= {stat_ff, 8'h00};
              reply_cnt_ff <= 2'd1;
              state_ff     <= S_SEND;
            end
            CMD_RD_CTL: begin
              reply_ff     <= {ctl_ff, 8'h00};
              reply_cnt_ff <= 2'd1;
              state_ff     <= S_SEND;
            end
            CMD_RD_BAUD: begin
              reply_ff     <= baud_reload;
              reply_cnt_ff <= 2'd2;
              state_ff     <= S_SEND;
            end
            CMD_PM_CRC: begin
              crc_ff      <= CRC_PRESET;
              crc_addr_ff <= '0;
              if (in_dbg) begin
                state_ff <= S_CRC_RD;
              end else begin
                reply_ff     <= BLOCKED_CRC;
                reply_cnt_ff <= 2'd2;
                state_ff     <= S_SEND;
              end
            end
            default: state_ff <= S_IDLE;
          endcase
        end
        S_HDR: if (rx_valid) begin
          hdr_ff     <= {hdr_ff[23:0], rx_data};
          hdr_cnt_ff <= hdr_cnt_ff + 3'd1;
          if (hdr_cnt_ff == 3'(HDR_BYTES-1)) begin
            // size zero stands for 65536
            left_ff  <= {({hdr_ff[7:0], rx_data} == 16'h0000),
                         hdr_ff[7:0], rx_data};
            hdr_ff   <= {hdr_ff[23:8], 16'h0000};
            state_ff <= (cmd_ff == CMD_WR_PM || cmd_ff == CMD_WR_DM) ?
                        S_WDATA : S_RD_ISSUE;
          end
        end
        S_WDATA: if (rx_valid) begin
          hdr_ff[31:16] <= hdr_ff[31:16] + 16'd1;
          left_ff       <= left_ff - 17'd1;
          if (left_ff == 17'd1) begin
            state_ff <= S_IDLE;
          end
        end
        S_RD_ISSUE: if (fifo_ready) begin
          state_ff <= S_RD_WAIT;
        end
        S_RD_WAIT: begin
          if (cmd_ff == CMD_RD_PM) begin
            byte_ff <= (in_dbg & ~rp_on) ? pm_rdata : BLOCKED_BYTE;
          end else begin
            byte_ff <= in_dbg ? dm_rdata : BLOCKED_BYTE;
          end
          state_ff <= S_RD_PUSH;
        end
        S_RD_PUSH: if (fifo_ready) begin
          hdr_ff[31:16] <= hdr_ff[31:16] + 16'd1;
          left_ff       <= left_ff - 17'd1;
          state_ff      <= (left_ff == 17'd1) ? S_IDLE : S_RD_ISSUE;
        end
        S_CRC_RD: begin
          crc_addr_ff <= crc_addr_ff + 17'd1;
          state_ff    <= S_CRC_ACC;
        end
        S_CRC_ACC: begin
          crc_ff <= crc_byte(crc_ff, pm_rdata);
          if (crc_addr_ff == 17'(PM_BYTES)) begin
            reply_ff     <= ~crc_byte(crc_ff, pm_rdata);
            reply_cnt_ff <= 2'd2;
            state_ff     <= S_SEND;
          end else begin
            state_ff <= S_CRC_RD;
          end
        end
        S_SEND: if (fifo_ready) begin
          reply_ff     <= {reply_ff[7:0], 8'h00};
          reply_cnt_ff <= reply_cnt_ff - 2'd1;
          if (reply_cnt_ff == 2'd1) begin
            state_ff <= S_IDLE;
          end
        end
        S_CTL: if (rx_valid) begin
          state_ff <= S_IDLE;
        end
        S_STUFF: if (rx_valid) begin
          state_ff <= S_IDLE;
        end
        S_EXEC: if (rx_valid) begin
          if (exec_left_ff == 3'd0) begin
            exec_left_ff <= (instr_len <= 3'd1) ? 3'd0 :
                            instr_len - 3'd1;
            if (instr_len <= 3'd1) begin
              state_ff <= S_IDLE;
            end
          end else begin
            exec_left_ff <= exec_left_ff - 3'd1;
            if (exec_left_ff == 3'd1) begin
              state_ff <= S_IDLE;
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // memory requests; writes are gated by debug mode and protection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pm_req <= '0;
      dm_req <= '0;
    end else begin
      pm_req.rd <= ((state_ff == S_RD_ISSUE) & fifo_ready &
                    (cmd_ff == CMD_RD_PM) & in_dbg & ~rp_on) |
                   (state_ff == S_CRC_RD);
      pm_req.wr <= (state_ff == S_WDATA) & rx_valid & (cmd_ff == CMD_WR_PM) &
                   in_dbg & ~rp_on & flash_unlocked;
      dm_req.rd <= (state_ff == S_RD_ISSUE) & fifo_ready &
                   (cmd_ff == CMD_RD_DM) & in_dbg;
      dm_req.wr <= (state_ff == S_WDATA) & rx_valid & (cmd_ff == CMD_WR_DM) &
                   in_dbg & ~rp_on;
      pm_req.addr  <= (state_ff == S_CRC_RD) ? crc_addr_ff[15:0] :
                      hdr_ff[31:16];
      dm_req.addr  <= hdr_ff[31:16];
      pm_req.wdata <= rx_data;
      dm_req.wdata <= rx_data;
    end
  end

  // instruction stepping, stuffing and execution strobes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      step_ff       <= 1'b0;
      stuff_ff      <= 1'b0;
      exec_valid_ff <= 1'b0;
      exec_byte_ff  <= '0;
      exec_last_ff  <= 1'b0;
    end else begin
      step_ff  <= (state_ff == S_IDLE) & rx_valid & (rx_data == CMD_STEP) &
                  in_dbg & ~rp_on;
      stuff_ff <= (state_ff == S_STUFF) & rx_valid & in_dbg & ~rp_on;
      exec_valid_ff <= (state_ff == S_EXEC) & rx_valid & in_dbg & ~rp_on;
      exec_byte_ff  <= rx_data;
      exec_last_ff  <= (state_ff == S_EXEC) & rx_valid &
                       (exec_left_ff == 3'd0 ? instr_len <= 3'd1 :
                        exec_left_ff == 3'd1);
    end
  end

  // control register: software write, hardware set wins over clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctl_ff <= CTL_RESET;
    end else begin
      if (ctl_write) begin
        ctl_ff <= rx_data;
      end else if (sys_reset_done) begin
        ctl_ff[CTL_SYS_RESET] <= 1'b0;
      end
      if (ack_push & fifo_ready & ~ctl_write) begin
        ctl_ff[CTL_ACK_SEND] <= 1'b0;
      end
      if ((brk_take & ~spin_cfg) | pc_hit | zero_hit) begin
        ctl_ff[CTL_HALT_FOR_DEBUG] <= 1'b1;
      end
      ctl_ff[CTL_SPIN] <= spin_cfg;
    end
  end

  // ack request on a breakpoint while enabled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_pend_ff <= 1'b0;
    end else if (brk_event & ctl_ff[CTL_ACK_SEND] & ~ack_pend_ff) begin
      ack_pend_ff <= 1'b1;
    end else if (ack_push & fifo_ready) begin
      ack_pend_ff <= 1'b0;
    end
  end

  // down counter: holds in pc-match mode, reloads on debug exit unless the counter-zero break is enabled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_ff <= CNT_RESET;
    end else if (ctl_write & in_dbg & ~rx_data[CTL_HALT_FOR_DEBUG] &
                 ~ctl_ff[CTL_CNT_ZERO]) begin
      cnt_ff <= CNT_RESET;
    end else if (running & ~ctl_ff[CTL_PC_MATCH] & (cnt_ff != '0)) begin
      cnt_ff <= cnt_ff - 16'd1;
    end
  end

  // status register; break since last control write is sticky
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idle_seen_ff <= 1'b0;
      stat_ff      <= '0;
    end else begin
      if (brk_take) begin
        idle_seen_ff <= 1'b1;
      end else if (ctl_write) begin
        idle_seen_ff <= 1'b0;
      end
      stat_ff[STAT_IDLE] <= in_dbg | idle_seen_ff | brk_take;
      stat_ff[STAT_HALT] <= halt_mode;
      stat_ff[STAT_RP]   <= rp_on;
    end
  end

  sequence s_hit;
    running & ctl_ff[CTL_PC_MATCH] & (pc == cnt_ff);
  endsequence

  a_pm_wr_gate: assert property (@(posedge clk) disable iff (!resetn)
    pm_req.wr |-> $past(in_dbg & ~rp_on & flash_unlocked))
    else $error("program write while blocked");
  a_dm_wr_gate: assert property (@(posedge clk) disable iff (!resetn)
    dm_req.wr |-> $past(in_dbg & ~rp_on))
    else $error("data write while blocked");
  a_pm_rd_block: assert property (@(posedge clk) disable iff (!resetn)
    pm_req.rd |-> $past(in_dbg))
    else $error("program read outside debug mode");
  a_step_gate: assert property (@(posedge clk) disable iff (!resetn)
    step_ff |-> $past(in_dbg & ~rp_on & rx_valid))
    else $error("step while blocked");
  a_pc_break: assert property (@(posedge clk) disable iff (!resetn)
    s_hit |=> ctl_ff[CTL_HALT_FOR_DEBUG])
    else $error("pc match did not halt");
  a_brk_halt: assert property (@(posedge clk) disable iff (!resetn)
    (brk_take & ~spin_cfg) |=> ctl_ff[CTL_HALT_FOR_DEBUG])
    else $error("break did not halt");
  a_brk_nop: assert property (@(posedge clk) disable iff (!resetn)
    (running & ~ctl_ff[CTL_BRK_ALLOW] & ~ctl_write & ~pc_hit & ~zero_hit)
    |=> ~ctl_ff[CTL_HALT_FOR_DEBUG])
    else $error("disabled break halted");
  a_ack_sent: assert property (@(posedge clk) disable iff (!resetn)
    (ack_pend_ff & ~fsm_push & fifo_ready & ~ctl_write)
    |=> ~ctl_ff[CTL_ACK_SEND] & ~ack_pend_ff)
    else $error("ack bit not cleared");
  a_idle_stat: assert property (@(posedge clk) disable iff (!resetn)
    in_dbg |=> stat_ff[STAT_IDLE])
    else $error("idle status low in debug mode");
  a_rp_stat: assert property (@(posedge clk) disable iff (!resetn)
    ##1 stat_ff[STAT_RP] == $past(~rp_option_n))
    else $error("protect status wrong");
  a_crc_block: assert property (@(posedge clk) disable iff (!resetn)
    (state_ff == S_IDLE & rx_valid & rx_data == CMD_PM_CRC & ~in_dbg)
    |=> (state_ff == S_SEND) & (reply_ff == BLOCKED_CRC))
    else $error("crc not blocked outside debug mode");

endmodule

// >>> tb/odc_mem_model.sv
// odc_mem_model: program and data memory behind the command unit.
// assumes one-cycle read and write pulses; read data stands while the
// read pulse stands, since the unit latches it at the end of that cycle.
`timescale 1ns/1ps
module odc_mem_model
  import odc_pkg::*;
(
  input  wire logic         clk,      // system clock
  input  wire odc_mem_req_s pm_req,   // program memory request
  output logic        [7:0] pm_rdata, // program read data
  input  wire odc_mem_req_s dm_req,   // data memory request
  output logic        [7:0] dm_rdata  // data read data
);
  logic [7:0] pm [256];
  logic [7:0] dm [256];
  // preset contents so every read has a known value
  initial begin
    for (int i = 0; i < 256; i++) begin
      pm[i] = 8'(i * 7 + 3);
      dm[i] = ~8'(i);
    end
  end
  // answer a read in its own cycle; a filler value otherwise
  assign pm_rdata = (pm_req.rd === 1'b1) ? pm[pm_req.addr[7:0]] : 8'h5a;
  assign dm_rdata = (dm_req.rd === 1'b1) ? dm[dm_req.addr[7:0]] : 8'ha5;
  // writes land at the edge after the write pulse
  always @(posedge clk) begin
    if (pm_req.wr === 1'b1) pm[pm_req.addr[7:0]] <= pm_req.wdata;
    if (dm_req.wr === 1'b1) dm[dm_req.addr[7:0]] <= dm_req.wdata;
  end
endmodule

// >>> tb/tb.sv
// tb: drives the host byte stream and checks reply bytes against a queue.
// assumes odc_unit with a 16-byte program memory and the memory model.
`timescale 1ns/1ps
module tb
  import odc_pkg::*;
;
  logic clk = 0, resetn = 0, rx_valid = 0, tx_ready = 1, tx_valid;
  logic [7:0] rx_data = 0, tx_data, pm_rdata, dm_rdata, d0, d1;
  logic rp_option_n = 1, halt_mode = 0, step_ff;
  logic fl = 1, break_instruction = 0, stuff_o, exv_o, exl_o;
  logic [7:0] exb_o, ctl_o, stat_o, last_op;
  logic [15:0] baud_reload = 0, pc = 0, crc, cnt_o, c;
  int stuffs = 0, execs = 0;
  odc_mem_req_s pm_req, dm_req;
  integer seed = 32'h2693, r;
  int fail_count = 0, check_count = 0, steps = 0;
  logic [7:0] exp_q [$];
  odc_unit #(.PM_BYTES(16)) odc_unit_inst (.clk(clk), .resetn(resetn),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .pm_req(pm_req),
    .pm_rdata(pm_rdata), .dm_req(dm_req), .dm_rdata(dm_rdata),
    .flash_unlocked(fl), .rp_option_n(rp_option_n),
    .halt_mode(halt_mode), .spin_cfg(1'b0), .brk_decoded(break_instruction), .pc(pc),
    .baud_reload(baud_reload), .instr_len(3'h1), .sys_reset_done(1'b0),
    .step_ff(step_ff), .stuff_ff(stuff_o), .exec_valid_ff(exv_o),
    .exec_byte_ff(exb_o), .exec_last_ff(exl_o), .ctl_ff(ctl_o),
    .stat_ff(stat_o), .cnt_ff(cnt_o));
  odc_mem_model odc_mem_model_inst (.clk(clk), .pm_req(pm_req),
    .pm_rdata(pm_rdata), .dm_req(dm_req), .dm_rdata(dm_rdata));
  // clock and watchdog
  always #5 clk = ~clk;
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
  // serial layer stalls at random
  always @(posedge clk) begin
    r = $random(seed);
    tx_ready <= r[0];
  end
  // count step, stuff and complete execute strobes; keep the stuffed opcode
  always @(posedge clk) begin
    if (step_ff === 1'b1) steps++;
    if (stuff_o === 1'b1) begin
      stuffs++;
      last_op = exb_o;
    end
    if (exv_o === 1'b1 && exl_o === 1'b1) execs++;
  end
  // compare each popped reply byte with the oldest note
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      check_count++;
      if (exp_q.size() == 0 || tx_data !== exp_q[0]) begin
        fail_count++;
        $display("[ERR] %0t reply byte %h unexpected", $time, tx_data);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tx(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
  endtask
  // command byte, then address and size high byte first
  task automatic hdr(input logic [7:0] c, input logic [15:0] a, s);
    tx(c);
    tx(a[15:8]);
    tx(a[7:0]);
    tx(s[15:8]);
    tx(s[7:0]);
  endtask
  // wait until all noted replies came out, bounded
  task automatic settle();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      $display("[ERR] %0t reply missing", $time);
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expect_b(input logic [7:0] b);
    exp_q.push_back(b);
  endtask
  // main sequence
  initial begin
    baud_reload = 16'($random(seed));
    pc = 16'($random(seed));
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    expect_b(CTL_RESET); tx(CMD_RD_CTL); settle();
    expect_b(8'hff); hdr(CMD_RD_PM, 16'h0000, 16'h0001); settle();
    expect_b(8'hff); expect_b(8'hff); tx(CMD_PM_CRC); settle();
    hdr(CMD_WR_DM, 16'h0020, 16'h0001); tx(8'h77); settle();
    tx(CMD_STEP); settle();
    chk(16'(steps), 16'h0000);
    tx(CMD_WR_CTL); tx(8'h80); settle();
    expect_b(8'h80); tx(CMD_RD_CTL); settle();
    expect_b(8'hdf); hdr(CMD_RD_DM, 16'h0020, 16'h0001); settle();
    hdr(CMD_WR_DM, 16'h0030, 16'h0002); tx(d0); tx(d1); settle();
    expect_b(d0); expect_b(d1);
    hdr(CMD_RD_DM, 16'h0030, 16'h0002); settle();
    for (int i = 5; i < 8; i++) expect_b(8'(i * 7 + 3));
    hdr(CMD_RD_PM, 16'h0005, 16'h0003); settle();
    crc = 16'hffff;
    for (int i = 0; i < 16; i++)
      for (int k = 0; k < 8; k++)
        crc = (crc[0] ^ r_bit(i, k)) ? (crc >> 1) ^ 16'h8408 : crc >> 1;
    expect_b(~crc[15:8]); expect_b(~crc[7:0]); tx(CMD_PM_CRC); settle();
    expect_b(baud_reload[15:8]); expect_b(baud_reload[7:0]);
    tx(CMD_RD_BAUD); settle();
    tx(CMD_STEP); settle();
    chk(16'(steps), 16'h0001);
    tx(CMD_STUFF); tx(8'h5e); tx(CMD_EXEC); tx(8'h8f); settle();
    chk(16'(stuffs), 16'h0001);
    chk(16'(last_op), 16'h005e);
    chk(16'(execs), 16'h0001);
    fl <= 1'b0;
    hdr(CMD_WR_PM, 16'h0002, 16'h0001); tx(8'h3c);
    fl <= 1'b1;
    hdr(CMD_WR_PM, 16'h0003, 16'h0001); tx(8'hc3);
    expect_b(8'h11); expect_b(8'hc3);
    hdr(CMD_RD_PM, 16'h0002, 16'h0002); settle();
    rp_option_n <= 1'b0;
    halt_mode   <= 1'b1;
    expect_b(8'he0); tx(CMD_RD_STATUS); settle();
    expect_b(8'hff); hdr(CMD_RD_PM, 16'h0000, 16'h0001); settle();
    expect_b(d0); hdr(CMD_RD_DM, 16'h0030, 16'h0001); settle();
    tx(CMD_STEP); settle();
    tx(CMD_STUFF); tx(8'h5e); tx(CMD_EXEC); tx(8'h8f); settle();
    chk(16'(steps), 16'h0001);
    chk(16'(stuffs + execs), 16'h0002);
    tx(CMD_WR_CTL); tx(8'h40); settle();
    expect_b(8'h40); tx(CMD_RD_CTL); settle();
    expect_b(8'h60); tx(CMD_RD_STATUS); settle();
    tx(CMD_WR_CTL); tx(8'h08); settle();
    pc <= cnt_o;
    expect_b(8'h88); tx(CMD_RD_CTL); settle();
    tx(CMD_WR_CTL); tx(8'h84); settle();
    c = cnt_o;
    repeat (8) @(posedge clk);
    chk(cnt_o, c);
    tx(CMD_WR_CTL); tx(8'h04); settle();
    chk(16'(cnt_o < c), 16'h0001);
    tx(CMD_WR_CTL); tx(8'h60); settle();
    expect_b(ACK_CHAR);
    break_instruction <= 1'b1;
    @(posedge clk) break_instruction <= 1'b0;
    settle();
    expect_b(8'hc0); tx(CMD_RD_CTL); settle();
    chk(16'(ctl_o), 16'h00c0);
    chk(16'(stat_o), 16'h00e0);
    wrap_up();
  end
  // bit k of preset program byte i, least significant first
  function automatic logic r_bit(input int i, k);
    logic [7:0] b;
    b = 8'(i * 7 + 3);
    return b[k];
  endfunction
endmodule
